// *** hdl/vectored_interrupt_arbiter.sv ***
`timescale 1ns/1ns
module vectored_interrupt_arbiter
    import via_pkg::*;
(
    input wire logic ref_clk, // 125 MHz clock
    input wire logic nrst, // Sync reset, active low
    input wire logic [3:0] reg_addr, // Register index
    input wire logic [31:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [31:0] reg_rdata, // Read data, cycle after strobe
    input wire logic low_voltage_irq, // Low-voltage detect pulse
    input wire logic [1:0] ext_pin_level, // Pins a, b levels
    input wire logic [1:0] ext_rise_en, // Rising edge enables
    input wire logic [1:0] ext_fall_en, // Falling edge enables
    input wire logic comparator_edge_irq, // Comparator edge pulse
    input wire logic serial_rx_done_irq, // Receive end or error
    input wire logic serial_tx_done_irq, // Transmit end
    input wire logic timer_h_match_irq, // Timer H match
    input wire logic wide_timer_ch_a_irq, // Wide timer channel a
    input wire logic wide_timer_ch_b_irq, // Wide timer channel b
    input wire logic adc_done_irq, // Conversion end
    input wire logic byte_timer_match_irq, // Byte timer match
    input wire logic carrier_transfer_signal, // Carrier transfer pulse
    input wire logic reset_pin, // External reset request
    input wire logic power_on_clear, // Power-on clear
    input wire logic watchdog_overflow, // Watchdog overflow
    input wire logic global_ie, // Core interrupt enable
    input wire logic software_break_instr, // Break executed, pulse
    input wire logic svc_done, // Return from service, pulse
    output logic irq_req, // Request to core; vector valid a cycle later
    output logic [15:0] irq_vector, // Vector address
    input wire logic irq_ack, // Core takes vector, pulse
    output logic standby_release, // Wakes stop and halt
    output logic reset_req, // Reset request to system
    output logic [15:0] reset_vector // Reset vector address
);
    logic [NSLOT-1:0] flag;
    logic [NSLOT-1:0] mask;
    logic [NSLOT-1:0] prio;
    logic [4:0] ctrl;
    logic [NSLOT-1:0] hw_set;
    logic [NSLOT-1:0] next_flag;
    logic [NSLOT-1:0] ack_clr;
    logic [1:0] pin_hit;
    logic brk_pend;
    logic take_brk;
    logic take_mask;
    logic may_take;
    via_svc_type svc;
    via_svc_type svc_prev;
    via_req_if req ();

    via_edge u_edge (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .lvl(ext_pin_level),
        .rise_en(ext_rise_en),
        .fall_en(ext_fall_en),
        .hit(pin_hit)
    );
    via_pick u_pick (
        .req(req)
    );

    // Source map; unused slots stay zero
    always_comb begin
        hw_set = '0;
        hw_set[S_LVI] = low_voltage_irq & ~ctrl[CTRL_LVSEL]; // R8
        hw_set[S_PA] = pin_hit[0]; // R10
        hw_set[S_PB] = pin_hit[1]; // R10
        hw_set[S_CMP] = comparator_edge_irq & ctrl[CTRL_CMPEN]; // R11
        hw_set[S_SRX] = serial_rx_done_irq; // R12
        hw_set[S_STX] = serial_tx_done_irq; // R12
        hw_set[S_TMH] = timer_h_match_irq & ctrl[CTRL_TMHCMP]; // R13
        hw_set[S_WTA] = wide_timer_ch_a_irq; // R14
        hw_set[S_WTB] = wide_timer_ch_b_irq; // R14
        hw_set[S_ADC] = adc_done_irq; // R15
        // Carrier mode swaps the trigger
        hw_set[S_BT] = ctrl[CTRL_CARRIER] ? carrier_transfer_signal : byte_timer_match_irq; // R16 R17
        hw_set = hw_set & SLOT_USED; // R22
    end

    assign req.pend = flag & ~mask; // R1
    assign req.group_high = prio; // R1
    // Nesting: idle takes any, low service takes only high group
    assign may_take = (svc == VIA_IDLE) || (svc == VIA_LOW && req.high); // R2
    assign take_brk = brk_pend; // R6
    assign take_mask = !brk_pend && global_ie && req.valid && may_take;
    assign irq_req = take_brk || take_mask;
    assign standby_release = req.valid; // R4

    // Vector out: break bypasses the arbiter entirely
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            irq_vector <= VEC_RESET;
        end else if (brk_pend) begin
            irq_vector <= VEC_BREAK; // R5 R6
        end else begin
            irq_vector <= VEC_BASE + {10'h000, req.slot, 1'b0}; // R3
        end
    end

    // Break is held until the core takes it
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            brk_pend <= 1'b0;
        end else if (software_break_instr) begin
            brk_pend <= 1'b1;
        end else if (irq_ack) begin
            brk_pend <= 1'b0;
        end
    end

    // Clear the flag of the taken slot
    always_comb begin
        ack_clr = '0;
        if (irq_ack && take_mask) begin
            ack_clr[req.slot] = 1'b1; // R18
        end
    end

    // New events win over clears in the same cycle
    always_comb begin
        next_flag = flag & ~ack_clr;
        if (reg_wr && reg_addr == A_FLAG) begin
            next_flag = reg_wdata[NSLOT-1:0] & SLOT_USED;
        end else if (reg_wr && reg_addr == A_FCLR) begin
            next_flag = next_flag & ~reg_wdata[NSLOT-1:0];
        end
        next_flag = next_flag | hw_set;
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            flag <= FLAG_RESET; // R19
        end else begin
            flag <= next_flag;
        end
    end

    // Mask, priority and control
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            mask <= MASK_RESET; // R20
            prio <= PRIO_RESET;
            ctrl <= 5'h00;
        end else if (reg_wr) begin
            case (reg_addr)
                A_MASK: mask <= reg_wdata[NSLOT-1:0];
                A_PRIO: prio <= reg_wdata[NSLOT-1:0];
                A_CTRL: ctrl <= reg_wdata[4:0];
                default: ;
            endcase
        end
    end

    // Service level, one nesting step saved
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            svc <= VIA_IDLE;
            svc_prev <= VIA_IDLE;
        end else if (irq_ack && take_mask) begin
            svc_prev <= svc;
            svc <= req.high ? VIA_HIGH : VIA_LOW; // R2
        end else if (svc_done) begin
            case (svc)
                VIA_HIGH: svc <= svc_prev;
                VIA_LOW: svc <= VIA_IDLE;
                default: svc <= VIA_IDLE;
            endcase
            svc_prev <= VIA_IDLE;
        end
    end

    // All reset sources share one vector; low voltage only when selected
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            reset_req <= 1'b0;
        end else begin
            reset_req <= reset_pin | power_on_clear | watchdog_overflow
                | (low_voltage_irq & ctrl[CTRL_LVSEL]); // R7 R9
        end
    end
    assign reset_vector = VEC_RESET; // R7

    // Read port, unmapped reads zero
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                A_FLAG: reg_rdata <= {3'h0, flag};
                A_MASK: reg_rdata <= {3'h0, mask};
                A_PRIO: reg_rdata <= {3'h0, prio};
                A_CTRL: reg_rdata <= {27'h0000000, ctrl};
                A_STAT: reg_rdata <= {21'h000000, brk_pend, svc_prev, svc, 4'h0, req.slot[1:0]};
                default: reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end
endmodule : vectored_interrupt_arbiter

// *** hdl/via_edge.sv ***
`timescale 1ns/1ns
module via_edge
    import via_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic nrst, // Sync reset, active low
    input wire logic [1:0] lvl, // Pin levels
    input wire logic [1:0] rise_en, // Rising edge enable
    input wire logic [1:0] fall_en, // Falling edge enable
    output logic [1:0] hit // Edge seen, one cycle
);
    logic [1:0] prev;
    // Previous level for edge detect; live level in reset, so a pin idling high gives no false edge
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            prev <= lvl;
        end else begin
            prev <= lvl;
        end
    end
    assign hit = (rise_en & lvl & ~prev) | (fall_en & ~lvl & prev);
endmodule : via_edge

// *** hdl/via_pick.sv ***
`timescale 1ns/1ns
module via_pick
    import via_pkg::*;
(
    via_req_if.arb req // Pending set in, winner out
);
    logic [NSLOT-1:0] hi_set;
    logic [NSLOT-1:0] lo_set;
    // Lowest set index wins
    function automatic logic [5:0] first_one(input logic [NSLOT-1:0] v);
        logic [5:0] r;
        r = 6'h3F;
        for (int i = NSLOT - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 6'(i);
            end
        end
        return r;
    endfunction : first_one
    logic [5:0] hi_win;
    logic [5:0] lo_win;
    // Group first, then default priority
    always_comb begin
        hi_set = req.pend & ~req.group_high;
        lo_set = req.pend & req.group_high;
        hi_win = first_one(hi_set); // R3
        lo_win = first_one(lo_set); // R3
    end
    assign req.high = |hi_set; // R21
    assign req.valid = |req.pend;
    assign req.slot = (|hi_set) ? hi_win[4:0] : lo_win[4:0]; // R21
endmodule : via_pick

// *** hdl/via_pkg.sv ***
// Operation
// R1: Each maskable source has a mask bit and a high/low priority group bit.
// R2: High-group request may nest over a low-group service in progress.
// R3: Equal group: smallest default priority number wins, 0 highest, 28 lowest.
// R4: Any pending unmasked request raises standby release for stop and halt.
// R5: Software break gives a vectored interrupt at 003EH.
// R6: Software break ignores global disable and skips priority arbitration.
// R7: Reset input, power-on clear, low voltage, watchdog all vector to 0000H.
// R8: Low voltage gives maskable request, priority 0, vector 0004H when select bit is 0.
// R9: Select bit 1 makes low voltage a reset source instead.
// R10: External pins a and b edges request priorities 1 and 2, vectors 0006H, 0008H.
// R11: Comparator edge requests priority 3, vector 000AH, on variants with comparator.
// R12: Serial receive priority 8 vector 0014H; transmit priority 9 vector 0016H.
// R13: Timer H match requests priority 11, vector 001AH, in compare mode.
// R14: Wide timer channels request priorities 14, 15, vectors 0020H, 0022H.
// R15: Conversion end requests priority 16, vector 0024H.
// R16: Byte timer match requests priority 19, vector 002AH.
// R17: In carrier mode byte timer request follows the carrier transfer signal.
// R18: Acknowledge clears that source's request flag before service.
// R19: Reset clears all request flags to zero.
// R20: Reset sets all mask flags to ones.
// R21: High group beats low group always; default priority decides within group.
// R22: Unassigned vector slots are never requested by hardware.
package via_pkg;
    localparam int NSLOT = 29;
    localparam logic [15:0] VEC_RESET = 16'h0000;
    localparam logic [15:0] VEC_BASE = 16'h0004;
    localparam logic [15:0] VEC_BREAK = 16'h003E;
    localparam logic [NSLOT-1:0] FLAG_RESET = 29'h00000000;
    localparam logic [NSLOT-1:0] MASK_RESET = 29'h1FFFFFFF;
    localparam logic [NSLOT-1:0] PRIO_RESET = 29'h1FFFFFFF;
    // Slots wired to a source: 0,1,2,3,8,9,11,14,15,16,19
    localparam logic [NSLOT-1:0] SLOT_USED = 29'h0009CB0F;
    localparam int S_LVI = 0;
    localparam int S_PA = 1;
    localparam int S_PB = 2;
    localparam int S_CMP = 3;
    localparam int S_SRX = 8;
    localparam int S_STX = 9;
    localparam int S_TMH = 11;
    localparam int S_WTA = 14;
    localparam int S_WTB = 15;
    localparam int S_ADC = 16;
    localparam int S_BT = 19;
    // Register indices on the plain port
    localparam logic [3:0] A_FLAG = 4'h0;
    localparam logic [3:0] A_MASK = 4'h1;
    localparam logic [3:0] A_PRIO = 4'h2;
    localparam logic [3:0] A_CTRL = 4'h3;
    localparam logic [3:0] A_STAT = 4'h4;
    localparam logic [3:0] A_FCLR = 4'h5;
    localparam int CTRL_LVSEL = 1;
    localparam int CTRL_CARRIER = 2;
    localparam int CTRL_CMPEN = 3;
    localparam int CTRL_TMHCMP = 4;
    typedef enum logic [1:0] {
        VIA_IDLE = 2'b00,
        VIA_LOW = 2'b01,
        VIA_HIGH = 2'b10
    } via_svc_type;
endpackage : via_pkg

// *** hdl/via_req_if.sv ***
`timescale 1ns/1ns
interface via_req_if;
    import via_pkg::*;
    logic [NSLOT-1:0] pend;
    logic [NSLOT-1:0] group_high;
    logic valid;
    logic [4:0] slot;
    logic high;
    modport arb (input pend, input group_high, output valid, output slot, output high);
    modport top (output pend, output group_high, input valid, input slot, input high);
endinterface : via_req_if

// *** verif/vectored_interrupt_arbiter_bench.sv ***
`timescale 1ns/1ns
module vectored_interrupt_arbiter_bench;
    import via_pkg::*;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [1:0] pins = 2'h0;
    logic [1:0] fall_en = 2'h0;
    logic [14:0] src = 15'h0;
    logic global_ie = 1'b0;
    logic take = 1'b0;
    logic irq_req, irq_ack, standby_release, reset_req;
    logic [15:0] irq_vector, reset_vector, last_vec;
    logic [31:0] reg_rdata, d;
    logic [7:0] ack_cnt;
    int error_cnt = 0;
    int checked = 0;
    int cyc = 0;
    int slots[9] = '{0, 3, 8, 9, 11, 14, 15, 16, 19};
    vectored_interrupt_arbiter vectored_interrupt_arbiter_i (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .low_voltage_irq(src[0]),
        .ext_pin_level(pins), .ext_rise_en(2'h3), .ext_fall_en(fall_en), .comparator_edge_irq(src[1]),
        .serial_rx_done_irq(src[2]), .serial_tx_done_irq(src[3]), .timer_h_match_irq(src[4]),
        .wide_timer_ch_a_irq(src[5]), .wide_timer_ch_b_irq(src[6]), .adc_done_irq(src[7]),
        .byte_timer_match_irq(src[8]), .carrier_transfer_signal(src[9]), .software_break_instr(src[10]),
        .reset_pin(src[11]), .power_on_clear(src[12]), .watchdog_overflow(src[13]), .svc_done(src[14]),
        .global_ie(global_ie), .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack),
        .standby_release(standby_release), .reset_req(reset_req), .reset_vector(reset_vector));
    via_core_model via_core_model_i (.ref_clk(ref_clk), .nrst(nrst), .take(take), .irq_req(irq_req),
        .irq_vector(irq_vector), .irq_ack(irq_ack), .last_vec(last_vec), .ack_cnt(ack_cnt));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask : rd
    task automatic pulse(input int k);
        @(posedge ref_clk);
        src[k] <= 1'b1;
        @(posedge ref_clk);
        src[k] <= 1'b0;
    endtask : pulse
    task automatic wait_acks(input int n);
        for (int i = 0; i < 100 && ack_cnt != n; i++) @(posedge ref_clk);
    endtask : wait_acks
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop
    always #4 ref_clk = ~ref_clk;
    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        rd(A_MASK);
        chk(d, 32'h1FFFFFFF);
        rd(A_FLAG);
        chk(d, 32'h0);
        chk(32'(reset_vector), 32'h0);
        rd(4'hF);
        chk(d, 32'h0);
        // No comparator and timer H not in compare mode: both stay silent
        pulse(1);
        pulse(4);
        rd(A_FLAG);
        chk(d, 32'h0);
        $display("test reset done");
        // Comparator present and timer H in compare mode, all still masked
        wr(A_CTRL, 32'h18);
        for (int k = 0; k < 9; k++) begin
            pulse(k);
            rd(A_FLAG);
            chk(d, 32'h1 << slots[k]);
            wr(A_FCLR, 32'h1FFFFFFF);
        end
        pins <= 2'h3;
        repeat (2) @(posedge ref_clk);
        rd(A_FLAG);
        chk(d, 32'h6);
        // Falling edge on pin a only
        wr(A_FCLR, 32'h1FFFFFFF);
        fall_en <= 2'h1;
        pins <= 2'h0;
        repeat (2) @(posedge ref_clk);
        rd(A_FLAG);
        chk(d, 32'h2);
        wr(A_CTRL, 32'h1C);
        wr(A_FCLR, 32'h1FFFFFFF);
        pulse(8);
        rd(A_FLAG);
        chk(d, 32'h0);
        pulse(9);
        rd(A_FLAG);
        chk(d, 32'h80000);
        wr(A_FLAG, 32'hFFFFFFFF);
        rd(A_FLAG);
        chk(d, 32'(SLOT_USED));
        wr(A_FCLR, 32'hFFFFFFFF);
        $display("test sources done");
        // Low voltage as reset source: other reset causes first, then low voltage sets no flag
        wr(A_CTRL, 32'h1E);
        for (int k = 11; k < 14; k++) begin
            pulse(k);
            @(negedge ref_clk);
            chk(32'(reset_req), 32'h1);
        end
        pulse(0);
        rd(A_FLAG);
        chk(d, 32'h0);
        $display("test reset sources done");
        // Low service blocks low, admits high; high wins at once
        wr(A_MASK, 32'h0);
        global_ie <= 1'b1;
        take <= 1'b1;
        wr(A_FLAG, 32'h10100);
        wait_acks(1);
        chk(32'(last_vec), 32'h14);
        repeat (4) @(negedge ref_clk);
        chk(32'(irq_req), 32'h0);
        wr(A_PRIO, 32'h1FFEFFFF);
        wait_acks(2);
        chk(32'(last_vec), 32'h24);
        pulse(14);
        pulse(14);
        rd(A_FLAG);
        chk(d, 32'h0);
        wr(A_FLAG, 32'h10100);
        wait_acks(3);
        chk(32'(last_vec), 32'h24);
        // High service from idle, low slot 8 waiting
        rd(A_STAT);
        chk(d, 32'h80);
        pulse(14);
        wait_acks(4);
        chk(32'(last_vec), 32'h14);
        pulse(14);
        $display("test arbitration done");
        // Wake-up needs no global enable; break ignores it
        take <= 1'b0;
        global_ie <= 1'b0;
        wr(A_FLAG, 32'h200);
        @(negedge ref_clk);
        chk(32'(standby_release), 32'h1);
        wr(A_MASK, 32'h200);
        @(negedge ref_clk);
        chk(32'(standby_release), 32'h0);
        take <= 1'b1;
        pulse(10);
        wait_acks(5);
        chk(32'(last_vec), 32'(VEC_BREAK));
        pulse(14);
        $display("test break done");
        report_and_stop();
    end
endmodule : vectored_interrupt_arbiter_bench
bind vectored_interrupt_arbiter via_properties via_properties_i (.ref_clk(ref_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .low_voltage_irq(low_voltage_irq), .reset_pin(reset_pin), .power_on_clear(power_on_clear),
    .watchdog_overflow(watchdog_overflow), .software_break_instr(software_break_instr), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_ack(irq_ack), .reset_req(reset_req), .reset_vector(reset_vector));

// *** verif/via_core_model.sv ***
`timescale 1ns/1ns
module via_core_model
    import via_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic nrst, // Sync reset, active low
    input wire logic take, // Core accepts requests
    input wire logic irq_req, // Request from arbiter
    input wire logic [15:0] irq_vector, // Offered vector
    output logic irq_ack, // One-cycle acknowledge
    output logic [15:0] last_vec, // Vector taken
    output logic [7:0] ack_cnt // Acknowledges so far
);
    logic seen;
    // Waits a cycle so the lagging vector has settled before taking it
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            seen <= 1'b0;
            irq_ack <= 1'b0;
            last_vec <= 16'h0000;
            ack_cnt <= 8'h00;
        end else begin
            seen <= irq_req && !irq_ack;
            irq_ack <= take && seen && irq_req && !irq_ack;
            if (irq_ack && irq_req) begin
                last_vec <= irq_vector;
                ack_cnt <= ack_cnt + 8'h01;
            end
        end
    end
endmodule : via_core_model

// *** verif/via_properties.sv ***
`timescale 1ns/1ns
module via_properties
    import via_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic nrst, // Sync reset, active low
    input wire logic [3:0] reg_addr, // Register index
    input wire logic [31:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    input wire logic [31:0] reg_rdata, // Read data
    input wire logic low_voltage_irq, // Low-voltage pulse
    input wire logic reset_pin, // External reset
    input wire logic power_on_clear, // Power-on clear
    input wire logic watchdog_overflow, // Watchdog overflow
    input wire logic software_break_instr, // Break pulse
    input wire logic irq_req, // Request to core
    input wire logic [15:0] irq_vector, // Offered vector
    input wire logic irq_ack, // Core acknowledge
    input wire logic reset_req, // Reset request out
    input wire logic [15:0] reset_vector // Reset vector
);
    logic lvsel;
    logic rcause;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // Shadow of the select bit, since the register itself is out of sight
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            lvsel <= 1'b0;
        end else if (reg_wr && reg_addr == A_CTRL) begin
            lvsel <= reg_wdata[CTRL_LVSEL];
        end
    end
    // Anything that may legally cause a system reset
    assign rcause = reset_pin || power_on_clear || watchdog_overflow || (low_voltage_irq && lvsel);
    property p_rvec; reset_vector == VEC_RESET; endproperty
    a_rvec: assert property (p_rvec) else $error("reset vector not zero");
    property p_rsrc; rcause |=> reset_req; endproperty
    a_rsrc: assert property (p_rsrc) else $error("reset cause without reset request");
    property p_rspur; reset_req |-> $past(rcause); endproperty
    a_rspur: assert property (p_rspur) else $error("reset request without cause");
    property p_brk; software_break_instr |-> ##[1:4] (irq_req && irq_vector == VEC_BREAK); endproperty
    a_brk: assert property (p_brk) else $error("break vector not offered");
    property p_mrst; !$past(nrst, 2) && !$past(reg_wr) && reg_rd && reg_addr == A_MASK |=> reg_rdata == 32'h1FFFFFFF;
    endproperty
    a_mrst: assert property (p_mrst) else $error("mask not all ones after reset");
    property p_unused; reg_rd && reg_addr == A_FLAG |=> (reg_rdata & ~32'(SLOT_USED)) == 32'h0; endproperty
    a_unused: assert property (p_unused) else $error("unwired slot flagged");
    property p_unmap; reg_rd && reg_addr > A_FCLR |=> reg_rdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside read cycle");
    c_ack: cover property (irq_ack && irq_req);
    c_brk: cover property (software_break_instr);
    c_rst: cover property (reset_req);
endmodule : via_properties
